// [ccdfr_fifo.sv]
// Pixel FIFO with registered output word
module ccdfr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_ce,
  ccdfr_stream_if.snk     s_in,
  ccdfr_stream_if.src     s_out
);

  localparam int ADDR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << ADDR_W) != DEPTH)
  begin : g_chk
    $error("ccdfr_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [ADDR_W-1:0] wr;
    logic [ADDR_W-1:0] rd;
    logic [ADDR_W:0]   cnt;
    logic              ovalid;
    logic [WIDTH-1:0]  odata;
  } ccdfr_fifo_st_t;

  ccdfr_fifo_st_t   q;
  ccdfr_fifo_st_t   d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             load;

  assign s_in.ready  = (q.cnt != (ADDR_W+1)'(DEPTH));
  assign s_out.valid = q.ovalid;
  assign s_out.data  = q.odata;

  always_comb
  begin
    d    = q;
    push = s_in.valid && s_in.ready;
    // Refill the output word whenever it is empty or being taken
    load = (q.cnt != '0) && (!q.ovalid || s_out.ready);
    if (push)
    begin
      d.wr = q.wr + 1'b1;
    end
    if (load)
    begin
      d.rd     = q.rd + 1'b1;
      d.odata  = mem[q.rd];
      d.ovalid = 1'b1;
    end
    else if (s_out.ready)
    begin
      d.ovalid = 1'b0;
    end
    if (push && !load)
    begin
      d.cnt = q.cnt + 1'b1;
    end
    else if (!push && load)
    begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      q <= '0;
    end
    else if (i_ce)
    begin
      q <= d;
      if (push)
      begin
        mem[q.wr] <= s_in.data;
      end
    end
  end

endmodule : ccdfr_fifo

// [ccdfr_pkg.sv]
// Shared constants and types for the CCD frame readout sequencer
package ccdfr_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int LEAD_DARK_PIX  = 4;
  localparam int ACTIVE_COLS    = 512;
  localparam int TRAIL_DARK_PIX = 8;
  localparam int LINE_PIX       = LEAD_DARK_PIX + ACTIVE_COLS + TRAIL_DARK_PIX;
  localparam int TOP_DARK_LINES = 4;
  localparam int ACTIVE_ROWS    = 512;
  localparam int BOT_DARK_LINES = 4;
  localparam int FRAME_LINES    = TOP_DARK_LINES + ACTIVE_ROWS + BOT_DARK_LINES;

  // ----------------------------------------------------------------
  // Counter widths and limits
  // ----------------------------------------------------------------
  localparam int COL_W   = 10;
  localparam int ROW_W   = 10;
  localparam int PSTEP_W = 4;
  localparam int VCNT_W  = 8;
  localparam int VSTEP_W = 2;

  localparam logic [COL_W-1:0] LAST_COL = COL_W'(LINE_PIX - 1);
  localparam logic [ROW_W-1:0] LAST_ROW = ROW_W'(FRAME_LINES - 1);

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  // Least dwell of each vertical phase state
  localparam int V_STEP_NS     = 1000;
  localparam int V_STEP_CYC    = (V_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [VCNT_W-1:0] V_STEP_LAST = VCNT_W'(V_STEP_CYC - 1);

  // Vertical transfer patterns, one per step
  localparam logic [VSTEP_W-1:0] VSTEP_MERGE  = 2'h0;
  localparam logic [VSTEP_W-1:0] VSTEP_INVERT = 2'h1;
  localparam logic [VSTEP_W-1:0] VSTEP_SECOND = 2'h2;
  localparam logic [VSTEP_W-1:0] VSTEP_END    = 2'h3;

  // Pixel cycle: ten clocks, one microsecond per pixel at 10 MHz
  localparam logic [PSTEP_W-1:0] PIX_LAST   = 4'h9;
  localparam logic [PSTEP_W-1:0] STEP_RST   = 4'h0;
  localparam logic [PSTEP_W-1:0] STEP_SREF  = 4'h2;
  localparam logic [PSTEP_W-1:0] STEP_HSWAP = 4'h5;
  localparam logic [PSTEP_W-1:0] STEP_SSIG  = 4'h6;
  // Strobe to synchronised sample: one cycle front end, two sync stages
  localparam logic [PSTEP_W-1:0] CAP_LAT    = 4'h3;
  localparam logic [PSTEP_W-1:0] STEP_CREF  = STEP_SREF + CAP_LAT;
  localparam logic [PSTEP_W-1:0] STEP_CSIG  = STEP_SSIG + CAP_LAT;

  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXPOSE,
    ST_VXFER,
    ST_HREAD
  } ccdfr_state_t;

endpackage : ccdfr_pkg

// [ccdfr_sensor_model.sv]
// Behavioural sensor array and sampling front end
module ccdfr_sensor_model (
  input  wire logic   i_mclk,
  input  wire logic   i_va,
  input  wire logic   i_vb,
  input  wire logic   i_h2,
  input  wire logic   i_ga,
  input  wire logic   i_gb,
  input  wire logic   i_node_reset,
  input  wire logic   i_sample_ref,
  input  wire logic   i_sample_sig,
  input  wire logic   i_shutter,
  output logic [13:0] o_video
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [13:0] REF_LVL = 14'h3fff;
  int          row  = 0;
  int          col  = 0;
  logic        vb_q = 1'b0;
  logic        h2_q = 1'b1;
  logic        gs_q = 1'b0;
  logic [1:0]  hold = 2'h0;
  logic [13:0] charge = 14'h0;

  // Dark border pixels carry no charge
  function automatic logic [13:0] pix_val(input int r, input int c);
    return (r < 4 || r > 515 || c < 4 || c > 515) ? 14'h0 : 14'(r * 16 + c);
  endfunction : pix_val

  initial o_video = 14'h0;

  always @(posedge i_mclk)
  begin
    vb_q <= i_vb;
    h2_q <= i_h2;
    gs_q <= i_ga || i_gb;
    if (i_shutter)
      row <= -1;
    if (i_vb && !vb_q)
    begin
      row <= row + 1;
      col <= 0;
    end
    // Charge reaches a node only through a gate that follows phase two
    if (!i_h2 && h2_q)
    begin
      charge <= gs_q ? pix_val(row, col) : 14'h0;
      col <= col + 1;
    end
    else if (i_node_reset)
      charge <= 14'h0;
    // Word held three cycles, then scrambled so a late read shows
    if (i_sample_ref || i_sample_sig)
    begin
      o_video <= i_sample_ref ? REF_LVL : REF_LVL - charge;
      hold <= 2'h2;
    end
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
    else
      o_video <= ~o_video;
  end
endmodule : ccdfr_sensor_model

// [ccdfr_seq_chk.sv]
// Concurrent checks on the sequencer ports
module ccdfr_seq_chk #(
  parameter int DATA_W = 14
) (
  input wire logic              i_mclk,
  input wire logic              i_resetn,
  input wire logic              i_ce,
  input wire logic              i_start,
  input wire logic              i_pix_ready,
  input wire logic              o_vertical_phase_a,
  input wire logic              o_vertical_phase_b,
  input wire logic              o_h_phase_1,
  input wire logic              o_h_phase_2,
  input wire logic              o_split_gate_a,
  input wire logic              o_split_gate_b,
  input wire logic              o_node_reset,
  input wire logic              o_sample_ref,
  input wire logic              o_sample_sig,
  input wire logic              o_shutter_open,
  input wire logic              o_strobe_fire,
  input wire logic              o_busy,
  input wire logic [DATA_W-1:0] o_pix_data,
  input wire logic              o_pix_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  wire va = o_vertical_phase_a;
  wire vb = o_vertical_phase_b;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  // ----------------------------------------------------------------
  // Vertical transfer steps
  // ----------------------------------------------------------------
  sequence s_merge;
    (va && !vb) [*8];
  endsequence
  sequence s_spill;
    !va && vb;
  endsequence
  sequence s_fwd;
    va && !vb;
  endsequence
  sequence s_end;
    !va && !vb;
  endsequence

  a_vxfer_order: assert property ($rose(va) && !$past(vb) |-> s_merge ##3 s_spill ##10 s_fwd ##10 s_end)
    else $error("vertical transfer out of order");
  a_expose_vlow: assert property (o_shutter_open |-> !va && !vb)
    else $error("vertical phase high during exposure");
  a_strobe_open: assert property (o_strobe_fire |-> o_shutter_open && !$past(o_shutter_open))
    else $error("strobe not at first exposure cycle");
  a_h_compl: assert property (o_h_phase_1 != o_h_phase_2)
    else $error("horizontal phases not complementary");
  a_pixel_steps: assert property (o_node_reset |-> o_h_phase_2 ##2 o_sample_ref ##3 $fell(o_h_phase_2) ##1 o_sample_sig)
    else $error("pixel cycle steps out of order");
  a_gate_follow: assert property (o_busy && $past(o_busy) |-> (!o_split_gate_b && o_split_gate_a == o_h_phase_2) || (!o_split_gate_a && o_split_gate_b == o_h_phase_2))
    else $error("split gate not following phase two");
  a_gate_fixed: assert property (o_busy && $past(o_busy, 2) && $past(o_split_gate_b) |-> !o_split_gate_a)
    else $error("output selection changed in frame");
  a_stream_hold: assert property (o_pix_valid && !i_pix_ready |=> o_pix_valid && $stable(o_pix_data))
    else $error("pixel word dropped while stalled");
  a_start_busy: assert property (!o_busy && i_start && i_ce |=> o_busy)
    else $error("start not taken while idle");
endmodule : ccdfr_seq_chk

bind ccdfr_sequencer ccdfr_seq_chk #(.DATA_W(DATA_W)) u_chk (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce), .i_start(i_start),
  .i_pix_ready(i_pix_ready), .o_vertical_phase_a(o_vertical_phase_a),
  .o_vertical_phase_b(o_vertical_phase_b), .o_h_phase_1(o_h_phase_1),
  .o_h_phase_2(o_h_phase_2), .o_split_gate_a(o_split_gate_a),
  .o_split_gate_b(o_split_gate_b), .o_node_reset(o_node_reset),
  .o_sample_ref(o_sample_ref), .o_sample_sig(o_sample_sig),
  .o_shutter_open(o_shutter_open), .o_strobe_fire(o_strobe_fire), .o_busy(o_busy),
  .o_pix_data(o_pix_data), .o_pix_valid(o_pix_valid)
);

// [ccdfr_sequencer.sv]
// Timing generator and CDS readout for a full-frame two-phase CCD
//
// What this block does
// (R01) Lines carry 4 lead, 8 trail dark pixels
// (R02) Frames carry 4 dark lines each end
// (R03) Active area is 512 by 512 pixels
// (R04) Shutter closed throughout readout; strobe at exposure
// (R05) Low gain: gate B blocks, A follows H2
// (R06) High gain: gate A blocks, B follows H2
// (R07) Pulse node reset after each pixel sampled
// (R08) Both vertical phases low during exposure
// (R09) Line transfer starts raising A, B low
// (R10) Then invert both vertical phases together
// (R11) Sensor moves row out on B rise
// (R12) Second transition, then A low ends transfer
// (R13) Horizontal phases complementary, one cycle per pixel
// (R14) Sensor dumps charge on H2 falling edge
// (R15) Rows move to serial register, then pixels out
// (R16) Repeat transfer and readout for every line
// (R17) One driver each for vertical phases A, B
// (R18) Correlated double sampling: reference, then signal
// (R19) 524 pixels per line, 520 lines per frame
// (R20) Output selection fixed for a whole frame
module ccdfr_sequencer #(
  parameter int DATA_W = 14,
  parameter int EXP_W  = 24,
  parameter int DEPTH  = ccdfr_pkg::FIFO_DEPTH
) (
  input  wire logic              i_mclk,
  input  wire logic              i_resetn,
  input  wire logic              i_ce,
  input  wire logic              i_start,
  input  wire logic              i_high_gain,
  input  wire logic [EXP_W-1:0]  i_exposure_cycles,
  input  wire logic [DATA_W-1:0] i_video_data,
  input  wire logic              i_pix_ready,
  output logic                   o_vertical_phase_a,
  output logic                   o_vertical_phase_b,
  output logic                   o_h_phase_1,
  output logic                   o_h_phase_2,
  output logic                   o_split_gate_a,
  output logic                   o_split_gate_b,
  output logic                   o_node_reset,
  output logic                   o_sample_ref,
  output logic                   o_sample_sig,
  output logic                   o_shutter_open,
  output logic                   o_strobe_fire,
  output logic                   o_busy,
  output logic                   o_frame_done,
  output logic [DATA_W-1:0]      o_pix_data,
  output logic                   o_pix_sof,
  output logic                   o_pix_eol,
  output logic                   o_pix_valid
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W < 2 || DATA_W > 30)
  begin : g_chk_data
    $error("ccdfr_sequencer: DATA_W out of range");
  end
  if (EXP_W < 1 || EXP_W > 32)
  begin : g_chk_exp
    $error("ccdfr_sequencer: EXP_W out of range");
  end
  if (ccdfr_pkg::V_STEP_CYC > (1 << ccdfr_pkg::VCNT_W))
  begin : g_chk_vstep
    $error("ccdfr_sequencer: vertical step too long for its counter");
  end

  localparam int PIX_W = DATA_W + 2;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ccdfr_pkg::ccdfr_state_t             state;
    logic [DATA_W-1:0]                   sync1;
    logic [DATA_W-1:0]                   sync2;
    logic                                hi_gain;
    logic [EXP_W-1:0]                    exp_cnt;
    logic [ccdfr_pkg::VSTEP_W-1:0]       vstep;
    logic [ccdfr_pkg::VCNT_W-1:0]        vcnt;
    logic [ccdfr_pkg::PSTEP_W-1:0]       pstep;
    logic [ccdfr_pkg::COL_W-1:0]         col;
    logic [ccdfr_pkg::ROW_W-1:0]         row;
    logic [DATA_W-1:0]                   ref_lvl;
    logic                                va;
    logic                                vb;
    logic                                h1;
    logic                                h2;
    logic                                sga;
    logic                                sgb;
    logic                                nrst;
    logic                                sref;
    logic                                ssig;
    logic                                shutter;
    logic                                strobe;
    logic                                done;
  } ccdfr_seq_st_t;

  ccdfr_seq_st_t   q;
  ccdfr_seq_st_t   d;
  logic            push_valid;
  logic [PIX_W-1:0] push_data;
  logic            stall;
  logic [DATA_W-1:0] cds_val;

  ccdfr_stream_if #(.WIDTH(PIX_W)) push_if ();
  ccdfr_stream_if #(.WIDTH(PIX_W)) pop_if ();

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    d          = q;
    push_valid = 1'b0;
    cds_val    = '0;
    d.done     = 1'b0;
    d.strobe   = 1'b0;
    // Video pins are asynchronous to i_mclk; two stages before use
    d.sync1    = i_video_data;
    d.sync2    = q.sync1;
    // Video falls as charge arrives: pixel is reference minus signal
    if (q.ref_lvl > q.sync2)
    begin
      cds_val = q.ref_lvl - q.sync2; // R18
    end
    push_data = {(q.row == '0) && (q.col == '0), q.col == ccdfr_pkg::LAST_COL, cds_val};
    // A full FIFO holds the pixel at its last step, H1 high, charge parked
    stall     = (q.state == ccdfr_pkg::ST_HREAD) && (q.pstep == ccdfr_pkg::PIX_LAST)
                && !push_if.ready;
    // The front end lets go of the signal word after a few cycles; keep it through a stall
    if (stall)
    begin
      d.sync2 = q.sync2; // R18
    end

    case (q.state)
      ccdfr_pkg::ST_IDLE:
      begin
        if (i_start)
        begin
          d.hi_gain = i_high_gain; // R20
          d.row     = '0;
          d.vstep   = ccdfr_pkg::VSTEP_MERGE;
          d.vcnt    = '0;
          if (i_exposure_cycles != '0)
          begin
            d.exp_cnt = i_exposure_cycles - 1'b1;
            d.state   = ccdfr_pkg::ST_EXPOSE;
            d.strobe  = 1'b1; // R04
          end
          else
          begin
            d.state = ccdfr_pkg::ST_VXFER;
          end
        end
      end

      ccdfr_pkg::ST_EXPOSE:
      begin
        if (q.exp_cnt == '0)
        begin
          d.state = ccdfr_pkg::ST_VXFER;
        end
        else
        begin
          d.exp_cnt = q.exp_cnt - 1'b1;
        end
      end

      ccdfr_pkg::ST_VXFER:
      begin
        if (q.vcnt == ccdfr_pkg::V_STEP_LAST)
        begin
          d.vcnt = '0;
          if (q.vstep == ccdfr_pkg::VSTEP_END)
          begin
            // Row now sits in the serial register; shift it out
            d.state = ccdfr_pkg::ST_HREAD; // R15
            d.pstep = '0;
            d.col   = '0;
          end
          else
          begin
            d.vstep = q.vstep + 1'b1;
          end
        end
        else
        begin
          d.vcnt = q.vcnt + 1'b1;
        end
      end

      ccdfr_pkg::ST_HREAD:
      begin
        if (q.pstep == ccdfr_pkg::STEP_CREF)
        begin
          d.ref_lvl = q.sync2; // R18
        end
        if (q.pstep == ccdfr_pkg::PIX_LAST)
        begin
          push_valid = 1'b1;
          if (!stall)
          begin
            d.pstep = '0;
            if (q.col == ccdfr_pkg::LAST_COL)
            begin
              d.col = '0; // R01 R19
              if (q.row == ccdfr_pkg::LAST_ROW)
              begin
                d.state = ccdfr_pkg::ST_IDLE; // R02 R03 R19
                d.done  = 1'b1;
              end
              else
              begin
                d.row   = q.row + 1'b1;
                d.state = ccdfr_pkg::ST_VXFER; // R16
                d.vstep = ccdfr_pkg::VSTEP_MERGE;
                d.vcnt  = '0;
              end
            end
            else
            begin
              d.col = q.col + 1'b1;
            end
          end
        end
        else
        begin
          d.pstep = q.pstep + 1'b1;
        end
      end

      default:
      begin
        d.state = ccdfr_pkg::ST_IDLE;
      end
    endcase

    // --------------------------------------------------------------
    // Pin levels derived from the next state, so every pin is a flop
    // --------------------------------------------------------------
    d.shutter = (d.state == ccdfr_pkg::ST_EXPOSE); // R04
    d.va      = 1'b0; // R08
    d.vb      = 1'b0; // R08
    if (d.state == ccdfr_pkg::ST_VXFER)
    begin
      case (d.vstep)
        ccdfr_pkg::VSTEP_MERGE:
        begin
          d.va = 1'b1; // R09
        end
        ccdfr_pkg::VSTEP_INVERT:
        begin
          d.vb = 1'b1; // R10 R11
        end
        ccdfr_pkg::VSTEP_SECOND:
        begin
          d.va = 1'b1; // R12
        end
        default:
        begin
          d.va = 1'b0; // R12
        end
      endcase
    end

    // Serial clocks idle with H2 high so the first fall is a real dump
    d.h1   = 1'b0;
    d.h2   = 1'b1;
    d.nrst = 1'b0;
    d.sref = 1'b0;
    d.ssig = 1'b0;
    if (d.state == ccdfr_pkg::ST_HREAD)
    begin
      d.h1   = (d.pstep >= ccdfr_pkg::STEP_HSWAP); // R13
      d.h2   = (d.pstep <  ccdfr_pkg::STEP_HSWAP); // R13 R14
      // Node reset opens the pixel, after the previous signal sample
      d.nrst = (d.pstep == ccdfr_pkg::STEP_RST); // R07
      d.sref = (d.pstep == ccdfr_pkg::STEP_SREF); // R18
      d.ssig = (d.pstep == ccdfr_pkg::STEP_SSIG); // R14 R18
    end
    d.sga = d.hi_gain ? 1'b0 : d.h2; // R05 R06
    d.sgb = d.hi_gain ? d.h2 : 1'b0; // R05 R06
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      q       <= '0;
      q.state <= ccdfr_pkg::ST_IDLE;
      q.h2    <= 1'b1;
    end
    else if (i_ce)
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Pixel FIFO
  // ----------------------------------------------------------------
  assign push_if.valid = push_valid;
  assign push_if.data  = push_data;
  assign pop_if.ready  = i_pix_ready;

  ccdfr_fifo #(
    .WIDTH (PIX_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .s_in     (push_if),
    .s_out    (pop_if)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Single net each for vertical A and B; all sensor pins share it
  assign o_vertical_phase_a = q.va; // R17
  assign o_vertical_phase_b = q.vb; // R17
  assign o_h_phase_1        = q.h1;
  assign o_h_phase_2        = q.h2;
  assign o_split_gate_a     = q.sga;
  assign o_split_gate_b     = q.sgb;
  assign o_node_reset       = q.nrst;
  assign o_sample_ref       = q.sref;
  assign o_sample_sig       = q.ssig;
  assign o_shutter_open     = q.shutter;
  assign o_strobe_fire      = q.strobe;
  assign o_busy             = (q.state != ccdfr_pkg::ST_IDLE);
  assign o_frame_done       = q.done;
  assign o_pix_data         = pop_if.data[DATA_W-1:0];
  assign o_pix_eol          = pop_if.data[DATA_W];
  assign o_pix_sof          = pop_if.data[DATA_W+1];
  assign o_pix_valid        = pop_if.valid;

endmodule : ccdfr_sequencer

// [ccdfr_stream_if.sv]
// Valid/ready stream carrier between sequencer and pixel FIFO
interface ccdfr_stream_if #(
  parameter int WIDTH = 16
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : ccdfr_stream_if

// [test_ccd_frame_readout_sequencer.sv]
// Self-checking bench for the CCD frame readout sequencer
module test_ccd_frame_readout_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct { logic hg; int unsigned expo; logic use_b; } ccdfr_case_t;
  ccdfr_case_t cases [2] = '{'{1'b0, 5, 1'b0}, '{1'b1, 12, 1'b1}};
  logic        clk, rstn, start, hg, ready, ce, done;
  logic [6:0]  frz;
  logic [23:0] expo;
  logic [13:0] video, pdata;
  logic        va, vb, h1, h2, ga, gb, nrst, sref, ssig, shut, strobe, busy, sof, eol, pvalid;
  int          miscompares, cmp_count, row_n, col_n, open_n, str_n, ga_n, gb_n, nr_n, dn_n;

  ccdfr_sequencer u_dut (
    .i_mclk(clk), .i_resetn(rstn), .i_ce(ce), .i_start(start), .i_high_gain(hg),
    .i_exposure_cycles(expo), .i_video_data(video), .i_pix_ready(ready),
    .o_vertical_phase_a(va), .o_vertical_phase_b(vb), .o_h_phase_1(h1), .o_h_phase_2(h2),
    .o_split_gate_a(ga), .o_split_gate_b(gb), .o_node_reset(nrst), .o_sample_ref(sref),
    .o_sample_sig(ssig), .o_shutter_open(shut), .o_strobe_fire(strobe), .o_busy(busy),
    .o_frame_done(done), .o_pix_data(pdata), .o_pix_sof(sof), .o_pix_eol(eol),
    .o_pix_valid(pvalid)
  );

  ccdfr_sensor_model u_model (
    .i_mclk(clk), .i_va(va), .i_vb(vb), .i_h2(h2), .i_ga(ga), .i_gb(gb), .i_node_reset(nrst),
    .i_sample_ref(sref), .i_sample_sig(ssig), .i_shutter(shut), .o_video(video)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [13:0] want_pix(input int r, input int c);
    return (r < 4 || r > 515 || c < 4 || c > 515) ? 14'h0 : 14'(r * 16 + c);
  endfunction : want_pix

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk_val(input logic [31:0] got, input logic [31:0] want, input string what);
    cmp_count++;
    if (got !== want)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic want, input string what);
    cmp_count++;
    if (got !== want)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %b want %b", $time, what, got, want);
    end
  endtask : chk_flag

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    {row_n, col_n, open_n, str_n, ga_n, gb_n, nr_n, dn_n} = '0;
  endtask : do_reset

  task automatic wait_lines(input int lines);
    int t;
    for (t = 0; t < 40000 && row_n < lines; t++)
      @(posedge clk);
    if (row_n < lines)
    begin
      miscompares++;
      $display("[FAIL] %0t readout stalled", $time);
      wrap_up();
    end
  endtask : wait_lines

  // ----------------------------------------------------------------
  // Stream consumer and pin counters
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    // Frozen cycles are not counted: the design does not advance on them
    if (rstn && ce && busy)
    begin
      open_n += shut;
      str_n += strobe;
      ga_n += sref & ga;
      gb_n += sref & gb;
      nr_n += nrst;
    end
    if (rstn && ce)
      dn_n += done;
    if (rstn && ce && pvalid && ready)
    begin
      chk_val(pdata, want_pix(row_n, col_n), "pixel");
      chk_flag(eol, col_n == 523, "end of line");
      chk_flag(sof, row_n == 0 && col_n == 0, "start of frame");
      col_n = (col_n == 523) ? 0 : col_n + 1;
      row_n += (col_n == 0);
    end
  end

  initial
  begin
    {start, hg, expo, ready, rstn, ce} = {1'b0, 1'b0, 24'h0, 1'b1, 1'b0, 1'b1};
    miscompares = 0;
    cmp_count = 0;
    do_reset();
    @(negedge clk);
    chk_val({busy, va, vb, h1, h2, shut, pvalid}, 7'h04, "reset levels");
    @(posedge clk);
    foreach (cases[i])
    begin
      do_reset();
      {start, hg, expo} <= {1'b1, cases[i].hg, 24'(cases[i].expo)};
      @(posedge clk);
      start <= 1'b0;
      wait_lines(2);
      chk_val(open_n, cases[i].expo, "exposure length");
      chk_val(str_n, 1, "strobe pulses");
      chk_flag(ga_n != 0, !cases[i].use_b, "low gain gate");
      chk_flag(gb_n != 0, cases[i].use_b, "high gain gate");
      chk_val(dn_n, 0, "frame ended early");
    end
    // Start is held high through the first six lines: it must be ignored while busy
    do_reset();
    {start, hg, expo} <= {1'b1, 1'b0, 24'h20};
    // Freeze mid-exposure for longer than the exposure itself
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    frz = {busy, shut, va, vb, h1, h2, nrst};
    repeat (50) @(posedge clk);
    chk_val({busy, shut, va, vb, h1, h2, nrst}, frz, "frozen by clock enable");
    ce <= 1'b1;
    wait_lines(1);
    chk_val(open_n, 32'h20, "exposure across freeze");
    chk_val(str_n, 1, "start ignored while busy");
    ready <= 1'b0;
    // 33 words of buffering fill well inside 800 cycles
    repeat (800) @(posedge clk);
    nr_n = 0;
    repeat (100) @(posedge clk);
    chk_val(nr_n, 0, "pixels stepped while full");
    chk_val({h1, h2, pvalid}, 3'h5, "stall levels");
    ready <= 1'b1;
    // Rows 4 and 5 are the first active rows, so CDS values are nonzero
    wait_lines(6);
    start <= 1'b0;
    do_reset();
    @(negedge clk);
    chk_val({busy, va, vb, h1, h2, shut, pvalid}, 7'h04, "mid frame reset");
    wrap_up();
  end
endmodule : test_ccd_frame_readout_sequencer
